/* File: src/csr_pkg.sv */
// package of constants and types for the common status reporting block
package csr_pkg;

   // avalon register map, byte addresses
   localparam logic [4:0] CSR_ADDR_STB = 5'h00;
   localparam logic [4:0] CSR_ADDR_ESR = 5'h04;
   localparam logic [4:0] CSR_ADDR_SRE = 5'h08;
   localparam logic [4:0] CSR_ADDR_ESE = 5'h0c;
   localparam logic [4:0] CSR_ADDR_CMD = 5'h10;
   localparam logic [4:0] CSR_ADDR_CFG = 5'h14;

   // status byte bit positions
   localparam int CSR_STB_OPER = 7;
   localparam int CSR_STB_RQS = 6;
   localparam int CSR_STB_ESB = 5;
   localparam int CSR_STB_MAV = 4;
   localparam int CSR_STB_QUES = 3;
   localparam logic [7:0] CSR_STB_USED = 8'hf8;
   localparam logic [7:0] CSR_SRE_USED = 8'hb8;
   localparam logic [7:0] CSR_COND_LOW = 8'h07;

   // standard event bit positions
   localparam int CSR_ESR_PON = 7;
   localparam int CSR_ESR_URQ = 6;
   localparam int CSR_ESR_CME = 5;
   localparam int CSR_ESR_EXE = 4;
   localparam int CSR_ESR_DDE = 3;
   localparam int CSR_ESR_QYE = 2;
   localparam int CSR_ESR_RQC = 1;
   localparam int CSR_ESR_OPC = 0;

   // reset values
   localparam logic [7:0] CSR_ESR_RST = 8'h80;
   localparam logic [7:0] CSR_ZERO8 = 8'h00;
   localparam logic [31:0] CSR_ZERO32 = 32'h0000_0000;

   // command word fields
   localparam logic [7:0] CSR_CMD_STAR = 8'h2a;
   localparam int CSR_CMD_HDR_LSB = 0;
   localparam int CSR_CMD_OP_LSB = 8;
   localparam int CSR_CMD_VAL_LSB = 16;
   localparam int CSR_CMD_TERM_BIT = 24;
   localparam int CSR_CFG_QUEUE_BIT = 0;

   typedef enum logic [3:0] {
      CSR_OP_NONE = 4'b0000,
      CSR_OP_CLS = 4'b0001,
      CSR_OP_ESE = 4'b0010,
      CSR_OP_SRE = 4'b0011,
      CSR_OP_OPC = 4'b0100
   } csr_op_type;

   typedef enum logic [1:0] {
      CSR_IDLE = 2'b00,
      CSR_OPC_WAIT = 2'b01
   } csr_state_type;

   // avalon-mm request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } csr_av_req_type;

   // conditions reported into the status byte
   typedef struct packed {
      logic oper_sum;
      logic ques_sum;
      logic oq_not_empty;
   } csr_cond_type;

endpackage

/* File: src/csr_srq.sv */
// service request generator and request-service bit of the status byte
`timescale 1ns/10ps
module csr_srq (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // summary bits of the status byte and enable mask
   input wire logic [7:0] summary_i,
   input wire logic [7:0] sre_i,
   // clear requests
   input wire logic poll_clr_i,
   input wire logic mss_clr_i,
   // request-service bit
   output logic rqs_o
);
   import csr_pkg::*;

   logic [7:0] prev_q;
   logic [7:0] rise;
   logic set_srq;

   // only 0 to 1 transitions count, so a bit stuck high asks once
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_rise
         assign rise[g] = summary_i[g] & ~prev_q[g] & sre_i[g];
      end
   endgenerate

   assign set_srq = |rise;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= CSR_ZERO8;
      end else begin
         prev_q <= summary_i;
      end
   end

   // a new request in the poll cycle wins over the clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rqs_o <= 1'b0;
      end else if (set_srq) begin
         rqs_o <= 1'b1;
      end else if (poll_clr_i || mss_clr_i) begin
         rqs_o <= 1'b0;
      end
   end
   // no clear from the summary dropping: the bit holds

endmodule // csr_srq

/* File: src/csr_status.sv */
// common status reporting registers with avalon-mm slave and serial poll
`timescale 1ns/10ps
module csr_status (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // avalon-mm slave
   input wire csr_pkg::csr_av_req_type AVS_REQ_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // instrument events and conditions
   input wire logic [7:0] EVENT_I,
   input wire csr_pkg::csr_cond_type COND_I,
   input wire logic OPC_DONE_I,
   // serial poll from the controller
   input wire logic SPOLL_I,
   output logic [7:0] SPOLL_DATA_O,
   output logic SPOLL_VALID_O,
   // service request and queue control
   output logic SRQ_O,
   output logic ERRQ_FLUSH_O,
   output logic OQ_FLUSH_O,
   output logic OPC_CANCEL_O,
   output logic [7:0] STB_O
);
   import csr_pkg::*;

   // masked view of the service request enable
   function automatic logic [7:0] sre_mask(input logic [7:0] v);
      sre_mask = v & CSR_SRE_USED;
   endfunction

   function automatic logic is_common(input logic [31:0] w);
      is_common = (w[CSR_CMD_HDR_LSB +: 8] == CSR_CMD_STAR);
   endfunction

   // one register hit: the strobe and the address both match
   function automatic logic hit(input logic strobe, input logic [4:0] addr,
                                input logic [4:0] reg_addr);
      hit = strobe && (addr == reg_addr);
   endfunction

   // a register byte zero-extended to the bus word
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h00_0000, b};
   endfunction

   logic waitreq_q;
   logic ack;
   logic rd_ack;
   logic wr_ack;
   logic rd_take;
   logic [31:0] rdata_q;
   logic [7:0] esr_q;
   logic [7:0] ese_q;
   logic [7:0] sre_q;
   logic [7:0] esr_taken_q;
   logic mav_q;
   logic rqs;
   logic esb;
   logic [7:0] summary;
   logic [7:0] stb;
   logic cmd_wr;
   logic cmd_ok;
   logic cmd_bad;
   csr_op_type cmd_op;
   logic [7:0] cmd_val;
   logic cmd_term;
   logic cls;
   logic cls_term;
   logic mss_clr;
   logic ese_ld;
   logic sre_ld;
   logic [7:0] ese_d;
   logic [7:0] sre_d;
   logic qmode_q;
   logic [7:0] esr_set;
   logic esr_rd_clr;
   csr_state_type state_q;
   logic errq_q;
   logic oqf_q;
   logic opcc_q;
   logic [7:0] poll_data_q;
   logic poll_valid_q;

   // bus handshake: one wait cycle, then the access is acknowledged
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         waitreq_q <= 1'b1;
      end else begin
         waitreq_q <= ~((AVS_REQ_I.read | AVS_REQ_I.write) & waitreq_q);
      end
   end

   assign ack = ~waitreq_q & (AVS_REQ_I.read | AVS_REQ_I.write);
   assign rd_ack = ack & AVS_REQ_I.read;
   assign wr_ack = ack & AVS_REQ_I.write & AVS_REQ_I.byteenable[0];
   assign rd_take = AVS_REQ_I.read & waitreq_q;

   // command word decode
   assign cmd_wr = hit(wr_ack, AVS_REQ_I.address, CSR_ADDR_CMD);
   assign cmd_ok = cmd_wr && is_common(AVS_REQ_I.writedata);
   assign cmd_bad = cmd_wr && !is_common(AVS_REQ_I.writedata);
   assign cmd_op = csr_op_type'(AVS_REQ_I.writedata[CSR_CMD_OP_LSB +: 4]);
   assign cmd_val = AVS_REQ_I.writedata[CSR_CMD_VAL_LSB +: 8];
   assign cmd_term = AVS_REQ_I.writedata[CSR_CMD_TERM_BIT];
   assign cls = cmd_ok && (cmd_op == CSR_OP_CLS);
   assign cls_term = cls && cmd_term;

   // the low condition bits are unused, so they always read zero here
   assign mss_clr = cls_term && ((stb & CSR_COND_LOW) == CSR_ZERO8);

   // enable loads from the command word or a direct register write
   always_comb begin
      ese_ld = 1'b0;
      sre_ld = 1'b0;
      ese_d = ese_q;
      sre_d = sre_q;
      if (cmd_ok && (cmd_op == CSR_OP_ESE)) begin
         ese_ld = 1'b1;
         ese_d = cmd_val;
      end else if (cmd_ok && (cmd_op == CSR_OP_SRE)) begin
         sre_ld = 1'b1;
         sre_d = sre_mask(cmd_val);
      end else if (hit(wr_ack, AVS_REQ_I.address, CSR_ADDR_ESE)) begin
         ese_ld = 1'b1;
         ese_d = AVS_REQ_I.writedata[7:0];
      end else if (hit(wr_ack, AVS_REQ_I.address, CSR_ADDR_SRE)) begin
         sre_ld = 1'b1;
         sre_d = sre_mask(AVS_REQ_I.writedata[7:0]);
      end
   end

   // enables change only by a load; zero clears, reset command never does
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ese_q <= CSR_ZERO8;
      end else if (ese_ld) begin
         ese_q <= ese_d;
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sre_q <= CSR_ZERO8;
      end else if (sre_ld) begin
         sre_q <= sre_d;
      end
   end

   // operation-complete tracking
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_q <= CSR_IDLE;
      end else begin
         unique case (state_q)
            CSR_IDLE: begin
               if (cmd_ok && (cmd_op == CSR_OP_OPC)) begin
                  state_q <= CSR_OPC_WAIT;
               end
            end
            CSR_OPC_WAIT: begin
               if (cls || OPC_DONE_I) begin
                  state_q <= CSR_IDLE;
               end
            end
            default: begin
               state_q <= CSR_IDLE;
            end
         endcase
      end
   end

   // event sources; bit weights follow the event layout
   always_comb begin
      esr_set = EVENT_I;
      if ((state_q == CSR_OPC_WAIT) && OPC_DONE_I && !cls) begin
         esr_set[CSR_ESR_OPC] = 1'b1;
      end
      if (cmd_bad || (cmd_ok && (cmd_op == CSR_OP_NONE))) begin
         esr_set[CSR_ESR_CME] = 1'b1;
      end
   end

   // what the bus read saw; only those bits are cleared on the ack
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         esr_taken_q <= CSR_ZERO8;
      end else if (hit(rd_take, AVS_REQ_I.address, CSR_ADDR_ESR)) begin
         esr_taken_q <= esr_q;
      end
   end

   assign esr_rd_clr = hit(rd_ack, AVS_REQ_I.address, CSR_ADDR_ESR);

   // a new event wins over read-clear, and over clear-status unless it is the OPC_DONE_I completion
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         esr_q <= CSR_ESR_RST;
      end else if (cls) begin
         esr_q <= esr_set;
      end else if (esr_rd_clr) begin
         esr_q <= (esr_q & ~esr_taken_q) | esr_set;
      end else begin
         esr_q <= esr_q | esr_set;
      end
   end

   // queue mode: when set, message-available follows the queue level
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         qmode_q <= 1'b1;
      end else if (hit(wr_ack, AVS_REQ_I.address, CSR_ADDR_CFG)) begin
         qmode_q <= AVS_REQ_I.writedata[CSR_CFG_QUEUE_BIT];
      end
   end

   // a flush masks the queue level in the command cycle and in the cycle the flush travels out
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mav_q <= 1'b0;
      end else if (cls_term || oqf_q) begin
         mav_q <= 1'b0;
      end else begin
         mav_q <= qmode_q & COND_I.oq_not_empty;
      end
   end

   assign esb = |(esr_q & ese_q);

   // status byte without the request-service bit
   always_comb begin
      summary = CSR_ZERO8;
      summary[CSR_STB_OPER] = COND_I.oper_sum;
      summary[CSR_STB_ESB] = esb;
      summary[CSR_STB_MAV] = mav_q;
      summary[CSR_STB_QUES] = COND_I.ques_sum;
   end

   csr_srq u_srq (
      .clk_i(MCLK_I),
      .rst_n_i(NRST_I),
      .summary_i(summary),
      .sre_i(sre_q),
      .poll_clr_i(SPOLL_I),
      .mss_clr_i(mss_clr),
      .rqs_o(rqs)
   );

   always_comb begin
      stb = summary;
      stb[CSR_STB_RQS] = rqs;
      stb = stb & CSR_STB_USED;
   end

   // bus read data captured in the wait cycle, held through the ack
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata_q <= CSR_ZERO32;
      end else if (rd_take) begin
         unique case (AVS_REQ_I.address)
            CSR_ADDR_STB: rdata_q <= byte_word(stb);
            CSR_ADDR_ESR: rdata_q <= byte_word(esr_q);
            CSR_ADDR_SRE: rdata_q <= byte_word(sre_mask(sre_q));
            CSR_ADDR_ESE: rdata_q <= byte_word(ese_q);
            CSR_ADDR_CFG: rdata_q <= {31'h0000_0000, qmode_q};
            default: rdata_q <= CSR_ZERO32;
         endcase
      end
   end

   // serial poll returns the live status byte of the poll cycle
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         poll_data_q <= CSR_ZERO8;
         poll_valid_q <= 1'b0;
      end else begin
         poll_valid_q <= SPOLL_I;
         if (SPOLL_I) begin
            poll_data_q <= stb;
         end
      end
   end

   // one-cycle strobes toward the queues and the sequencer
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         errq_q <= 1'b0;
      end else begin
         errq_q <= cls;
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         oqf_q <= 1'b0;
      end else begin
         oqf_q <= cls_term;
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         opcc_q <= 1'b0;
      end else begin
         opcc_q <= cls && (state_q == CSR_OPC_WAIT);
      end
   end

   // the srq line is the registered request-service bit
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         SRQ_O <= 1'b0;
      end else begin
         SRQ_O <= stb[CSR_STB_RQS];
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         STB_O <= CSR_ZERO8;
      end else begin
         STB_O <= stb;
      end
   end

   assign AVS_READDATA_O = rdata_q;
   assign AVS_WAITREQUEST_O = waitreq_q;
   assign SPOLL_DATA_O = poll_data_q;
   assign SPOLL_VALID_O = poll_valid_q;
   assign ERRQ_FLUSH_O = errq_q;
   assign OQ_FLUSH_O = oqf_q;
   assign OPC_CANCEL_O = opcc_q;

endmodule // csr_status

/* File: test/csr_ctrl_model.sv */
// bus controller model: issues serial polls and keeps the poll result
`timescale 1ns/10ps
module csr_ctrl_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // poll trigger from the bench
   input wire logic poll_i,
   // serial poll interface
   input wire logic [7:0] spoll_data_i,
   input wire logic spoll_valid_i,
   output logic spoll_o,
   output logic [7:0] result_o,
   output logic got_o
);
   // a held trigger gives single-cycle polls, one every second cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) spoll_o <= 1'b0;
      else spoll_o <= poll_i && !spoll_o;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= 8'h00;
         got_o <= 1'b0;
      end else if (spoll_valid_i) begin
         result_o <= spoll_data_i;
         got_o <= 1'b1;
      end else if (spoll_o) begin
         got_o <= 1'b0;
      end
   end
endmodule // csr_ctrl_model

/* File: test/csr_status_sva.sv */
// assertion checker for the common status reporting block
`timescale 1ns/10ps
module csr_status_sva (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // avalon-mm slave
   input wire csr_pkg::csr_av_req_type AVS_REQ_I,
   input wire logic AVS_WAITREQUEST_O,
   // serial poll, service request, status
   input wire logic SPOLL_I,
   input wire logic [7:0] SPOLL_DATA_O,
   input wire logic SPOLL_VALID_O,
   input wire logic SRQ_O,
   input wire logic ERRQ_FLUSH_O,
   input wire logic OQ_FLUSH_O,
   input wire logic OPC_CANCEL_O,
   input wire logic [7:0] STB_O
);
   import csr_pkg::*;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   wait_one_a: assert property ($rose(AVS_REQ_I.read || AVS_REQ_I.write)
      |=> !AVS_WAITREQUEST_O) else $error("no ack one cycle after request");
   ack_short_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("ack held longer than one cycle");
   poll_answer_a: assert property (SPOLL_I |=> SPOLL_VALID_O
      ##1 !SPOLL_VALID_O) else $error("poll answer missing or too long");
   unused_zero_a: assert property (STB_O[2:0] == 3'h0
      && SPOLL_DATA_O[2:0] == 3'h0)
      else $error("unused status bits not zero");
   rqs_srq_a: assert property ($rose(STB_O[CSR_STB_RQS])
      |-> ##[0:1] SRQ_O)
      else $error("request-service bit without service request");
   // the only ways out: a poll two edges back, or a flush around now
   rqs_keep_a: assert property ($fell(STB_O[CSR_STB_RQS]) |->
      $past(SPOLL_I, 2) || $past(OQ_FLUSH_O, 2) ||
      $past(OQ_FLUSH_O) || OQ_FLUSH_O)
      else $error("request-service bit cleared without poll");
   err_pulse_a: assert property (ERRQ_FLUSH_O |=> !ERRQ_FLUSH_O)
      else $error("error flush longer than one cycle");
   oq_err_a: assert property (OQ_FLUSH_O |-> ERRQ_FLUSH_O)
      else $error("output flush without error flush");
   cancel_cls_a: assert property (OPC_CANCEL_O |-> ERRQ_FLUSH_O)
      else $error("cancel without clear status");
   mav_clear_a: assert property (OQ_FLUSH_O
      |-> ##[0:1] !STB_O[CSR_STB_MAV])
      else $error("message available kept after flush");
endmodule // csr_status_sva

bind csr_status csr_status_sva u_sva (.MCLK_I, .NRST_I, .AVS_REQ_I,
   .AVS_WAITREQUEST_O, .SPOLL_I, .SPOLL_DATA_O, .SPOLL_VALID_O, .SRQ_O,
   .ERRQ_FLUSH_O, .OQ_FLUSH_O, .OPC_CANCEL_O, .STB_O);

/* File: test/csr_status_tb.sv */
// self-checking testbench of the common status reporting block
`timescale 1ns/10ps
module csr_status_tb;
   import csr_pkg::*;
   logic clk, nrst, wrq, opc_done, spoll, spv, srq, errf, oqf, canc;
   logic poll, pgot, s_err, s_oq, s_can;
   logic [7:0] ev, spd, stb, pres;
   logic [31:0] rd, q, v;
   csr_av_req_type req;
   csr_cond_type cond;
   int n_errors, n_compared, cyc;
   csr_status dut (.MCLK_I(clk), .NRST_I(nrst), .AVS_REQ_I(req),
      .AVS_READDATA_O(rd), .AVS_WAITREQUEST_O(wrq), .EVENT_I(ev),
      .COND_I(cond), .OPC_DONE_I(opc_done), .SPOLL_I(spoll),
      .SPOLL_DATA_O(spd), .SPOLL_VALID_O(spv), .SRQ_O(srq),
      .ERRQ_FLUSH_O(errf), .OQ_FLUSH_O(oqf), .OPC_CANCEL_O(canc),
      .STB_O(stb));
   csr_ctrl_model u_ctrl (.clk_i(clk), .rst_n_i(nrst), .poll_i(poll),
      .spoll_data_i(spd), .spoll_valid_i(spv), .spoll_o(spoll),
      .result_o(pres), .got_o(pgot));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until the edge that sees waitrequest low
   task automatic av(input logic r, input logic [4:0] a,
                     input logic [31:0] d);
      req <= '{r, !r, a, 4'hf, d};
      do @(posedge clk); while (wrq !== 1'b0);
      q = rd;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      av(1'b1, a, 32'h0);
      chk(q, e);
   endtask
   task automatic evp(input logic [7:0] e);
      ev <= e;
      @(posedge clk);
      ev <= 8'h00;
      tick(3);
   endtask
   task automatic dopoll;
      poll <= 1'b1;
      @(posedge clk);
      poll <= 1'b0;
      tick(4);
   endtask
   function automatic logic [31:0] cw(logic t, logic [7:0] x, logic [3:0] op);
      return {7'h00, t, x, 4'h0, op, CSR_CMD_STAR};
   endfunction
   function automatic logic [31:0] sre_exp(logic [7:0] x);
      return {24'h000000, x & CSR_SRE_USED};
   endfunction
   // pulse catchers, and the output queue drains on a flush
   always @(posedge clk) begin
      cyc++;
      if (errf === 1'b1) s_err <= 1'b1;
      if (oqf === 1'b1) s_oq <= 1'b1;
      if (canc === 1'b1) s_can <= 1'b1;
      if (oqf === 1'b1) cond.oq_not_empty <= 1'b0;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      nrst = 1'b0;
      req = '0;
      ev = 8'h00;
      cond = '0;
      opc_done = 1'b0;
      poll = 1'b0;
      s_err = 1'b0;
      s_oq = 1'b0;
      s_can = 1'b0;
      q = $urandom(32'hc395);
      tick(8);
      nrst <= 1'b1;
      @(posedge clk);
      rdc(CSR_ADDR_ESR, 32'h80);
      rdc(CSR_ADDR_ESR, 32'h00);
      rdc(CSR_ADDR_ESE, 32'h00);
      rdc(CSR_ADDR_STB, 32'h00);
      rdc(5'h18, 32'h00);
      rdc(CSR_ADDR_CMD, 32'h00);
      for (int i = 0; i < 8; i++) begin
         v = $urandom & 32'hff;
         if (i < 2) v = i ? 32'hff : 32'h00;
         av(1'b0, CSR_ADDR_SRE, v);
         rdc(CSR_ADDR_SRE, sre_exp(v[7:0]));
         av(1'b0, CSR_ADDR_CMD, cw(1'b0, v[7:0], CSR_OP_ESE));
         rdc(CSR_ADDR_ESE, v);
         evp(~v[7:0]);
         rdc(CSR_ADDR_ESR, {24'h0, ~v[7:0]});
      end
      av(1'b0, CSR_ADDR_SRE, 32'h0);
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_ESE));
      rdc(CSR_ADDR_ESE, 32'h0);
      dopoll;
      chk(stb[6], 1'b0);
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h10, CSR_OP_ESE));
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h20, CSR_OP_SRE));
      rdc(CSR_ADDR_SRE, 32'h20);
      evp(8'h08);
      chk(srq, 1'b0);
      evp(8'h10);
      chk(srq, 1'b1);
      chk(stb[6:5], 2'b11);
      rdc(CSR_ADDR_ESR, 32'h18);
      tick(3);
      chk(stb[6:5], 2'b10);
      dopoll;
      chk(pgot, 1'b1);
      chk(pres, 8'h40);
      chk(stb[6], 1'b0);
      v = $urandom;
      cond <= '{v[1], v[0], 1'b0};
      tick(3);
      chk({stb[7], stb[3]}, v[1:0]);
      av(1'b0, CSR_ADDR_SRE, 32'h10);
      cond.oq_not_empty <= 1'b1;
      evp(8'h04);
      chk(stb[6:4], 3'b101);
      s_err <= 1'b0;
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_CLS));
      tick(3);
      chk(s_err, 1'b1);
      rdc(CSR_ADDR_ESR, 32'h0);
      chk(stb[6:4], 3'b101);
      rdc(CSR_ADDR_ESE, 32'h10);
      s_oq <= 1'b0;
      av(1'b0, CSR_ADDR_CMD, cw(1'b1, 8'h00, CSR_OP_CLS));
      tick(4);
      chk(s_oq, 1'b1);
      chk(stb[6:4], 3'b000);
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_OPC));
      s_can <= 1'b0;
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_CLS));
      tick(3);
      chk(s_can, 1'b1);
      opc_done <= 1'b1;
      tick(1);
      opc_done <= 1'b0;
      tick(3);
      rdc(CSR_ADDR_ESR, 32'h0);
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_OPC));
      opc_done <= 1'b1;
      tick(1);
      opc_done <= 1'b0;
      tick(3);
      rdc(CSR_ADDR_ESR, 32'h1);
      s_err <= 1'b0;
      av(1'b0, CSR_ADDR_CMD, {24'h000001, 8'h2b});
      tick(3);
      chk(s_err, 1'b0);
      rdc(CSR_ADDR_ESR, 32'h20);
      av(1'b0, CSR_ADDR_CMD, cw(1'b0, 8'h00, CSR_OP_NONE));
      rdc(CSR_ADDR_ESR, 32'h20);
      av(1'b0, CSR_ADDR_CFG, 32'h0);
      rdc(CSR_ADDR_CFG, 32'h0);
      cond.oq_not_empty <= 1'b1;
      tick(3);
      chk(stb[4], 1'b0);
      av(1'b0, CSR_ADDR_CFG, 32'h1);
      rdc(CSR_ADDR_CFG, 32'h1);
      chk(stb[6:4], 3'b101);
      report_and_stop();
   end
endmodule // csr_status_tb
